// *** shared/rcfg_pkg.sv ***
// Constants and types for the reset-cause and flash-guard block
`default_nettype none
package rcfg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_RESET_SOURCE_FLAGS = 10'h0ef;
  localparam logic [9:0] IDX_WATCHDOG_CONTROL = 10'h0f0;
  localparam logic [9:0] ADDR_SCALE = 10'h004;
  // Reset-source bit positions
  localparam int B_PIN = 0;
  localparam int B_POR = 1;
  localparam int B_MCLK = 2;
  localparam int B_WDOG = 3;
  localparam int B_SW = 4;
  localparam int B_CMP = 5;
  localparam int B_FERR = 6;
  localparam int B_ONE = 7;
  // Watchdog control bit positions
  localparam int W_EN = 0;
  localparam int W_KICK = 1;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MCLK_TIMEOUT_NS = 100000;
  localparam int MCLK_CYCLES_I = (MCLK_TIMEOUT_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
  localparam logic [9:0] MCLK_CYCLES = MCLK_CYCLES_I[9:0];
  localparam logic [3:0] WDOG_PRESCALE = 4'hb;
  localparam logic [7:0] WDOG_LIMIT = 8'hff;
  localparam logic [3:0] RESET_HOLD = 4'h7;
  // Reset values and flash constants
  localparam logic [6:0] FLAGS_POR = 7'h02;
  localparam logic [7:0] FLASH_ERASED = 8'hff;
  localparam logic [15:0] XDATA8_LIMIT = 16'h00ff;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [0:0] {
    RCFG_RUN = 1'b0,
    RCFG_HOLD = 1'b1
  } rcfg_state_t;
endpackage : rcfg_pkg
`default_nettype wire

// *** hw/rcfg_reset_guard.sv ***
// Reset-cause register, reset sources and flash access guard
// Notes on behaviour
// - Watchdog comes up enabled after every reset, ticking at clock/12.
// - Watchdog timeout resets the system and sets cause bit 3.
// - Store-enabled data write above lock byte gives a flash error reset.
// - Code-memory read above lock byte gives a flash error reset.
// - Branch fetch above lock byte gives a flash error reset.
// - Access forbidden by flash security gives a flash error reset.
// - Flash write/erase with monitor off or low threshold gives error reset.
// - Bit 6 reads 1 only after a flash error reset.
// - Writing 1 to bit 4 forces reset, then reads 1; 0 does nothing.
// - Internal resets never drive the external reset pin.
// - Bit 7 always reads 1; writes ignored.
// - Bit 5 enables comparator source; reads comparator cause.
// - Bit 2 enables missing-clock reset; reads missing-clock cause.
// - Bit 1 set by power-on; write selects supply monitor as source.
// - After power-on flag, other cause flags are indeterminate.
// - Bit 0 reads 1 only after an external pin reset.
// - Flash write/erase self-timed; core stalled until done.
// - Flash write only clears bits; erase leaves 0xff.
// - 8-bit data writes cannot program flash above 0x00ff.
// - Clock level stuck over 100 us triggers missing-clock reset.
// - Enabled comparator resets while non-inverting input is lower.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rcfg_reset_guard #(
  parameter int FLASH_WRITE_CYCLES = 400,
  parameter int FLASH_ERASE_CYCLES = 200000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire logic reset_pin_n,
  input wire logic system_clock_source,
  input wire logic comparator_out,
  input wire logic supply_monitor_enable,
  input wire logic supply_monitor_threshold_select,
  input wire logic supply_monitor_trip,
  input wire logic flash_security_violation,
  input wire logic [15:0] lock_byte_addr,
  input wire logic program_store_write_enable,
  input wire logic program_store_erase_enable,
  input wire logic external_data_move_wr,
  input wire logic external_data_move_8bit,
  input wire logic [15:0] external_data_move_addr,
  input wire logic [7:0] external_data_move_data,
  input wire logic code_memory_read,
  input wire logic [15:0] code_memory_read_addr,
  input wire logic branch_fetch,
  input wire logic [15:0] branch_fetch_addr,
  input wire logic [7:0] flash_current_data,
  output logic system_reset_n,
  output logic core_stall,
  output logic flash_program,
  output logic flash_erase,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_program_data
);

  typedef struct packed {
    rcfg_pkg::rcfg_state_t st;
    logic [3:0] hold_cnt;
    logic pin_hold;
    logic [6:0] flags;
    logic comp_en;
    logic mclk_en;
    logic mon_sel;
    logic wdog_en;
    logic [3:0] presc;
    logic [7:0] wdog_cnt;
    logic mclk_last;
    logic [9:0] mclk_cnt;
    logic [17:0] busy_cnt;
    logic prog;
    logic erase;
    logic [15:0] faddr;
    logic [7:0] fdata;
    logic dp_wr;
    logic [9:0] dp_idx;
    logic [31:0] rdata;
  } rcfg_regs_t;

  rcfg_regs_t s_q;
  rcfg_regs_t s_d;

  localparam logic [17:0] WR_CYC = FLASH_WRITE_CYCLES[17:0];
  localparam logic [17:0] ER_CYC = FLASH_ERASE_CYCLES[17:0];

  function automatic logic [9:0] word_idx(input logic [31:0] a);
    word_idx = a[11:2];
  endfunction : word_idx

  function automatic logic above_lock(input logic [15:0] a,
                                      input logic [15:0] lock);
    above_lock = a > lock;
  endfunction : above_lock

  logic accept;
  logic run;
  logic sw_force;
  logic flash_attempt;
  logic flash_err;
  logic wdog_timeout;
  logic mclk_timeout;
  logic cmp_trip;
  logic mon_trip;
  logic [6:0] cause;
  logic [7:0] reg_view;

  // Single-cycle slave: address phase taken on hready, data next cycle
  assign accept = hsel && htrans[1] && hready;
  assign run = (s_q.st == rcfg_pkg::RCFG_RUN);
  assign sw_force = s_q.dp_wr && run
      && s_q.dp_idx == rcfg_pkg::IDX_RESET_SOURCE_FLAGS
      && hwdata[rcfg_pkg::B_SW];
  assign flash_attempt = external_data_move_wr
      && program_store_write_enable && run && s_q.busy_cnt == 18'h00000;
  assign flash_err = run && (
      (flash_attempt && above_lock(external_data_move_addr,
                                   lock_byte_addr))
      || (code_memory_read && above_lock(code_memory_read_addr,
                                         lock_byte_addr))
      || (branch_fetch && above_lock(branch_fetch_addr,
                                     lock_byte_addr))
      || flash_security_violation
      || (flash_attempt && !(supply_monitor_enable
          && supply_monitor_threshold_select)));
  assign wdog_timeout = s_q.wdog_en && s_q.wdog_cnt == rcfg_pkg::WDOG_LIMIT
      && s_q.presc == rcfg_pkg::WDOG_PRESCALE;
  assign mclk_timeout = s_q.mclk_en
      && s_q.mclk_cnt >= rcfg_pkg::MCLK_CYCLES;
  assign cmp_trip = s_q.comp_en && !comparator_out;
  assign mon_trip = s_q.mon_sel && supply_monitor_enable
      && supply_monitor_trip;

  // One cause at a time, highest priority first
  always_comb begin
    cause = 7'h00;
    if (mon_trip) begin
      cause[rcfg_pkg::B_POR] = 1'b1;
    end else if (mclk_timeout) begin
      cause[rcfg_pkg::B_MCLK] = 1'b1;
    end else if (flash_err) begin
      cause[rcfg_pkg::B_FERR] = 1'b1;
    end else if (wdog_timeout) begin
      cause[rcfg_pkg::B_WDOG] = 1'b1;
    end else if (cmp_trip) begin
      cause[rcfg_pkg::B_CMP] = 1'b1;
    end else if (sw_force) begin
      cause[rcfg_pkg::B_SW] = 1'b1;
    end
  end

  assign reg_view = {1'b1, s_q.flags};

  always_comb begin
    s_d = s_q;
    s_d.dp_wr = accept && hwrite;
    s_d.dp_idx = word_idx(haddr);
    if (accept && !hwrite) begin
      if (word_idx(haddr) == rcfg_pkg::IDX_RESET_SOURCE_FLAGS) begin
        s_d.rdata = {24'h000000, reg_view};
      end else if (word_idx(haddr) == rcfg_pkg::IDX_WATCHDOG_CONTROL) begin
        s_d.rdata = {16'h0000, s_q.wdog_cnt, 7'h00, s_q.wdog_en};
      end else begin
        s_d.rdata = rcfg_pkg::ZERO_WORD;
      end
    end
    // Register writes; only enables are stored, cause bits stay latched
    if (s_q.dp_wr && run) begin
      if (s_q.dp_idx == rcfg_pkg::IDX_RESET_SOURCE_FLAGS) begin
        s_d.comp_en = hwdata[rcfg_pkg::B_CMP];
        s_d.mclk_en = hwdata[rcfg_pkg::B_MCLK];
        s_d.mon_sel = hwdata[rcfg_pkg::B_POR];
      end else if (s_q.dp_idx == rcfg_pkg::IDX_WATCHDOG_CONTROL) begin
        s_d.wdog_en = hwdata[rcfg_pkg::W_EN];
        if (hwdata[rcfg_pkg::W_KICK]) begin
          s_d.wdog_cnt = 8'h00;
          s_d.presc = 4'h0;
        end
      end
    end
    // Watchdog ticks once per twelve clocks
    if (s_q.wdog_en && run) begin
      if (s_q.presc == rcfg_pkg::WDOG_PRESCALE) begin
        s_d.presc = 4'h0;
        s_d.wdog_cnt = s_q.wdog_cnt + 8'h01;
      end else begin
        s_d.presc = s_q.presc + 4'h1;
      end
    end
    // Stuck-level detector on the sampled clock source
    s_d.mclk_last = system_clock_source;
    if (!s_q.mclk_en || system_clock_source != s_q.mclk_last) begin
      s_d.mclk_cnt = 10'h000;
    end else if (!mclk_timeout) begin
      s_d.mclk_cnt = s_q.mclk_cnt + 10'h001;
    end
    // Self-timed flash operation; core stalls meanwhile
    s_d.prog = 1'b0;
    s_d.erase = 1'b0;
    if (s_q.busy_cnt != 18'h00000) begin
      s_d.busy_cnt = s_q.busy_cnt - 18'h00001;
    end
    if (flash_attempt && !flash_err
        && !(external_data_move_8bit
             && external_data_move_addr > rcfg_pkg::XDATA8_LIMIT)) begin
      s_d.faddr = external_data_move_addr;
      if (program_store_erase_enable) begin
        s_d.erase = 1'b1;
        s_d.fdata = rcfg_pkg::FLASH_ERASED;
        s_d.busy_cnt = ER_CYC;
      end else begin
        s_d.prog = 1'b1;
        s_d.fdata = flash_current_data & external_data_move_data;
        s_d.busy_cnt = WR_CYC;
      end
    end
    // Reset sequencing; the external pin is input only
    unique case (s_q.st)
      rcfg_pkg::RCFG_RUN: begin
        if (!reset_pin_n) begin
          s_d.st = rcfg_pkg::RCFG_HOLD;
          s_d.pin_hold = 1'b1;
          s_d.hold_cnt = rcfg_pkg::RESET_HOLD;
          s_d.flags = 7'h01 << rcfg_pkg::B_PIN;
        end else if (cause != 7'h00) begin
          s_d.st = rcfg_pkg::RCFG_HOLD;
          s_d.pin_hold = 1'b0;
          s_d.hold_cnt = rcfg_pkg::RESET_HOLD;
          s_d.flags = cause;
        end
      end
      rcfg_pkg::RCFG_HOLD: begin
        // Internal causes reset internal state only
        s_d.wdog_en = 1'b1;
        s_d.wdog_cnt = 8'h00;
        s_d.presc = 4'h0;
        s_d.comp_en = 1'b0;
        s_d.mclk_en = 1'b0;
        s_d.mclk_cnt = 10'h000;
        s_d.busy_cnt = 18'h00000;
        if (!reset_pin_n) begin
          s_d.hold_cnt = rcfg_pkg::RESET_HOLD;
        end else if (s_q.hold_cnt != 4'h0) begin
          s_d.hold_cnt = s_q.hold_cnt - 4'h1;
        end else begin
          s_d.st = rcfg_pkg::RCFG_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.st <= rcfg_pkg::RCFG_RUN;
      s_q.flags <= rcfg_pkg::FLAGS_POR;
      s_q.mon_sel <= 1'b1;
      s_q.wdog_en <= 1'b1;
      s_q.mclk_last <= 1'b0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = rcfg_pkg::HRESP_OKAY;
  assign hrdata = s_q.rdata;
  assign system_reset_n = run;
  assign core_stall = s_q.busy_cnt != 18'h00000;
  assign flash_program = s_q.prog;
  assign flash_erase = s_q.erase;
  assign flash_addr = s_q.faddr;
  assign flash_program_data = s_q.fdata;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !clk_en);

  a_sw_force_reset: assert property (
    sw_force && reset_pin_n && !mon_trip && !mclk_timeout && !flash_err
      && !wdog_timeout && !cmp_trip
    |=> !system_reset_n && s_q.flags[rcfg_pkg::B_SW])
    else $error("software force did not reset");
  a_bit7_high: assert property (
    accept && !hwrite && word_idx(haddr) == rcfg_pkg::IDX_RESET_SOURCE_FLAGS
    |=> hrdata[rcfg_pkg::B_ONE])
    else $error("top bit of reset source not one");
  a_flash_err_flag: assert property (
    flash_err && reset_pin_n && !mon_trip && !mclk_timeout
    |=> s_q.flags == (7'h01 << rcfg_pkg::B_FERR))
    else $error("flash error cause not latched alone");
  a_pin_reset: assert property (
    run && !reset_pin_n |=> !system_reset_n ##0
      s_q.flags[rcfg_pkg::B_PIN])
    else $error("pin reset not taken");
  a_wdog_after_reset: assert property (
    !system_reset_n ##1 system_reset_n
    |-> s_q.wdog_en && s_q.wdog_cnt == 8'h00)
    else $error("watchdog not enabled after reset");
  a_write_clears_only: assert property (
    flash_program |-> (flash_program_data & ~$past(flash_current_data))
      == 8'h00)
    else $error("flash write sets a bit");
  a_erase_value: assert property (
    flash_erase |-> flash_program_data == rcfg_pkg::FLASH_ERASED)
    else $error("erase value wrong");
  a_stall_busy: assert property (
    flash_program || flash_erase |-> core_stall)
    else $error("core not stalled during flash op");
  a_mclk_reset: assert property (
    run && mclk_timeout && reset_pin_n && !mon_trip
    |=> !system_reset_n && s_q.flags[rcfg_pkg::B_MCLK])
    else $error("missing clock reset not taken");
  a_monitor_gate: assert property (
    run && flash_attempt && !supply_monitor_threshold_select && reset_pin_n
      && !mon_trip && !mclk_timeout |=> !system_reset_n ##0 !flash_program)
    else $error("flash write with low monitor not blocked");
  a_wdog_timeout: assert property (
    run && wdog_timeout && reset_pin_n && !mon_trip && !mclk_timeout
      && !flash_err
    |=> !system_reset_n && s_q.flags == (7'h01 << rcfg_pkg::B_WDOG))
    else $error("watchdog timeout cause not latched alone");
  a_cmp_reset: assert property (
    run && cmp_trip && reset_pin_n && !mon_trip && !mclk_timeout
      && !flash_err && !wdog_timeout
    |=> !system_reset_n && s_q.flags[rcfg_pkg::B_CMP])
    else $error("comparator reset not taken");
  a_mon_reset: assert property (
    run && mon_trip && reset_pin_n
    |=> !system_reset_n && s_q.flags == (7'h01 << rcfg_pkg::B_POR))
    else $error("supply monitor reset not taken");
  a_pin_flag_only: assert property (
    run && !reset_pin_n |=> s_q.flags == (7'h01 << rcfg_pkg::B_PIN))
    else $error("pin reset left other cause flags set");
  a_read_flags: assert property (
    accept && !hwrite && word_idx(haddr) == rcfg_pkg::IDX_RESET_SOURCE_FLAGS
    |=> hrdata == {24'h000000, 1'b1, $past(s_q.flags)})
    else $error("reset source read does not show latched causes");
  a_enable_write: assert property (
    s_q.dp_wr && run && s_q.dp_idx == rcfg_pkg::IDX_RESET_SOURCE_FLAGS
    |=> s_q.comp_en == $past(hwdata[rcfg_pkg::B_CMP])
      && s_q.mclk_en == $past(hwdata[rcfg_pkg::B_MCLK])
      && s_q.mon_sel == $past(hwdata[rcfg_pkg::B_POR]))
    else $error("source enables not taken from write");
  a_presc_range: assert property (
    s_q.presc <= rcfg_pkg::WDOG_PRESCALE)
    else $error("watchdog prescaler beyond twelve states");
  a_err_no_write: assert property (
    flash_err |=> !flash_program && !flash_erase)
    else $error("flash changed on an error access");
  a_narrow_block: assert property (
    run && flash_attempt && external_data_move_8bit
      && external_data_move_addr > rcfg_pkg::XDATA8_LIMIT
    |=> !flash_program && !flash_erase)
    else $error("narrow data write reached flash");
  a_write_busy: assert property (
    flash_program |-> s_q.busy_cnt == WR_CYC)
    else $error("write not timed by hardware");
  a_erase_busy: assert property (
    flash_erase |-> s_q.busy_cnt == ER_CYC)
    else $error("erase not timed by hardware");
endmodule : rcfg_reset_guard
`default_nettype wire

// *** sim/rcfg_core_model.sv ***
// Core-side model: data writes, code reads and branch fetches as pulses
`timescale 1ns/1ps
`default_nettype none
module rcfg_core_model (
  input wire logic hclk,
  output logic wr,
  output logic narrow,
  output logic [15:0] waddr,
  output logic [7:0] wdata,
  output logic crd,
  output logic [15:0] caddr,
  output logic bfe,
  output logic [15:0] baddr
);
  initial begin
    {wr, narrow, crd, bfe} = 4'h0;
    {waddr, caddr, baddr} = 48'h000000000000;
    wdata = 8'h00;
  end
  // Released lines show the inverse so a stale value never looks valid
  task automatic issue(input logic [1:0] k, input logic [15:0] a,
                       input logic [7:0] d, input logic n8);
    @(posedge hclk);
    wr <= (k == 2'h0);
    crd <= (k == 2'h1);
    bfe <= (k == 2'h2);
    {waddr, caddr, baddr} <= {a, a, a};
    wdata <= d;
    narrow <= n8;
    @(posedge hclk);
    {wr, crd, bfe} <= 3'h0;
    {waddr, caddr, baddr} <= {~a, ~a, ~a};
    wdata <= ~d;
  endtask : issue
endmodule : rcfg_core_model
`default_nettype wire

// *** sim/test_reset_cause_and_flash_guard.sv ***
// Self-checking bench for the reset-cause and flash-guard block
`timescale 1ns/1ps
`default_nettype none
module test_reset_cause_and_flash_guard;
  localparam logic [9:0] RSF = rcfg_pkg::IDX_RESET_SOURCE_FLAGS;
  localparam logic [9:0] WDC = rcfg_pkg::IDX_WATCHDOG_CONTROL;
  localparam int LIMIT = 20000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout, system_reset_n, core_stall, flash_program, flash_erase;
  logic [1:0] hresp;
  logic [31:0] hrdata, rd, r;
  logic [15:0] flash_addr, xd_addr, cm_addr, br_addr;
  logic [7:0] flash_program_data, xd_data;
  logic xd_wr, xd_8bit, cm_rd, br_f;
  logic reset_pin_n = 1'b1;
  logic sys_clk_src = 1'b0;
  logic sc_run = 1'b1;
  logic cmp_out = 1'b1;
  logic mon_en = 1'b1;
  logic mon_hi = 1'b1;
  logic mon_trip = 1'b0;
  logic sec_viol = 1'b0;
  logic [15:0] lock_addr = 16'h1dff;
  logic erase_en = 1'b0;
  logic store_en = 1'b0;
  logic [7:0] cur_data = 8'hff;
  logic [31:0] seed = 32'h00000062;
  logic [7:0] cnt0;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;

  always #50 hclk = ~hclk;
  always @(posedge hclk) begin
    if (sc_run)
      sys_clk_src <= ~sys_clk_src;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      close_out();
    end
  end

  rcfg_reset_guard #(.FLASH_WRITE_CYCLES(4), .FLASH_ERASE_CYCLES(8))
    u_rcfg_reset_guard (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .reset_pin_n(reset_pin_n), .system_clock_source(sys_clk_src),
    .comparator_out(cmp_out), .supply_monitor_enable(mon_en),
    .supply_monitor_threshold_select(mon_hi),
    .supply_monitor_trip(mon_trip), .flash_security_violation(sec_viol),
    .lock_byte_addr(lock_addr), .program_store_write_enable(store_en),
    .program_store_erase_enable(erase_en), .external_data_move_wr(xd_wr),
    .external_data_move_8bit(xd_8bit), .external_data_move_addr(xd_addr),
    .external_data_move_data(xd_data), .code_memory_read(cm_rd),
    .code_memory_read_addr(cm_addr), .branch_fetch(br_f),
    .branch_fetch_addr(br_addr), .flash_current_data(cur_data),
    .system_reset_n(system_reset_n), .core_stall(core_stall),
    .flash_program(flash_program), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .flash_program_data(flash_program_data));

  rcfg_core_model u_rcfg_core_model (.hclk(hclk), .wr(xd_wr),
    .narrow(xd_8bit), .waddr(xd_addr), .wdata(xd_data), .crd(cm_rd),
    .caddr(cm_addr), .bfe(br_f), .baddr(br_addr));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] exp_flags(input int k);
    case (k)
      0: return 32'h00000090;
      6: return 32'h00000081;
      7: return 32'h000000a0;
      8: return 32'h00000082;
      9: return 32'h00000088;
      10: return 32'h00000084;
      default: return 32'h000000c0;
    endcase
  endfunction : exp_flags

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h00000, idx, 2'h0};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    chk("hresp", 32'(hresp), 32'(rcfg_pkg::HRESP_OKAY));
  endtask : ahb

  task automatic wait_rst(input logic lvl, input int bound);
    int n;
    n = 0;
    while (system_reset_n !== lvl && n < bound) begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk("system_reset_n", 32'(system_reset_n), 32'(lvl));
  endtask : wait_rst

  task automatic provoke(input int k);
    logic [31:0] q;
    logic [15:0] hi;
    q = xs();
    hi = lock_addr + 16'h0001 + {4'h0, q[11:0]};
    case (k)
      0: ahb(1'b1, RSF, 32'h00000012, q);
      1: begin
        store_en <= 1'b1;
        u_rcfg_core_model.issue(2'h0, hi, q[23:16], 1'b0);
      end
      2: u_rcfg_core_model.issue(2'h1, hi, 8'h00, 1'b0);
      3: u_rcfg_core_model.issue(2'h2, hi, 8'h00, 1'b0);
      4: sec_viol <= 1'b1;
      5: begin
        mon_hi <= 1'b0;
        store_en <= 1'b1;
        u_rcfg_core_model.issue(2'h0, 16'h0040, q[7:0], 1'b0);
      end
      6: begin
        reset_pin_n <= 1'b0;
        repeat (3) @(posedge hclk);
        reset_pin_n <= 1'b1;
      end
      7: begin
        ahb(1'b1, RSF, 32'h00000022, q);
        cmp_out <= 1'b0;
      end
      8: mon_trip <= 1'b1;
      9: ;
      10: begin
        ahb(1'b1, WDC, 32'h00000000, q);
        ahb(1'b1, RSF, 32'h00000006, q);
        sc_run <= 1'b0;
      end
      default: ;
    endcase
    wait_rst(1'b0, 4000);
    {store_en, sec_viol, mon_trip} <= 3'h0;
    {mon_hi, cmp_out, sc_run} <= 3'h7;
    wait_rst(1'b1, 60);
    ahb(1'b0, RSF, 32'h00000000, q);
    chk("reset_source_flags", q, exp_flags(k));
    $display("test cause %0d done", k);
  endtask : provoke

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, RSF, 32'h00000000, rd);
    chk("flags after power-on", rd, 32'h00000082);
    ahb(1'b0, WDC, 32'h00000000, rd);
    chk("watchdog enable", 32'(rd[0]), 32'h00000001);
    cnt0 = rd[15:8];
    // Reads 120 cycles apart span exactly ten prescaler periods
    repeat (117) @(posedge hclk);
    ahb(1'b0, WDC, 32'h00000000, rd);
    chk("watchdog ticks", 32'(rd[15:8] - cnt0), 32'h0000000a);
    ahb(1'b1, WDC, 32'h00000003, rd);
    ahb(1'b0, WDC, 32'h00000000, rd);
    chk("watchdog restart", rd, 32'h00000001);
    ahb(1'b0, 10'h010, 32'h00000000, rd);
    chk("unmapped read", rd, 32'h00000000);
    ahb(1'b1, RSF, 32'h00000002, rd);
    repeat (3) @(posedge hclk);
    #1;
    chk("no reset on zero", 32'(system_reset_n), 32'h00000001);
    ahb(1'b0, RSF, 32'h00000000, rd);
    chk("flags kept", rd, 32'h00000082);
    $display("test register done");
    for (int i = 0; i < 6; i++) begin
      r = xs();
      erase_en <= r[0];
      store_en <= 1'b1;
      cur_data <= r[31:24];
      u_rcfg_core_model.issue(2'h0, {7'h00, r[8:0]}, r[23:16], 1'b0);
      #1;
      chk("pulse", 32'({flash_program, flash_erase}),
          r[0] ? 32'h00000001 : 32'h00000002);
      chk("flash_addr", 32'(flash_addr), 32'(r[8:0]));
      chk("flash data", 32'(flash_program_data), r[0] ?
          32'(rcfg_pkg::FLASH_ERASED) : 32'(r[31:24] & r[23:16]));
      chk("core_stall", 32'(core_stall), 32'h00000001);
      for (int n = 0; n < 30 && core_stall !== 1'b0; n++) @(posedge hclk);
      #1;
      chk("stall ends", 32'(core_stall), 32'h00000000);
    end
    erase_en <= 1'b0;
    r = xs();
    u_rcfg_core_model.issue(2'h0, {8'h01, r[7:0]}, r[15:8], 1'b1);
    #1;
    chk("narrow write blocked", 32'(flash_program), 32'h00000000);
    chk("no error reset", 32'(system_reset_n), 32'h00000001);
    store_en <= 1'b0;
    $display("test flash done");
    for (int k = 0; k < 11; k++)
      provoke(k);
    close_out();
  end
endmodule : test_reset_cause_and_flash_guard
`default_nettype wire
